// ### touch_adc_serial_conversion_control.sv
`timescale 1ns/1ps
module touch_adc_serial_conversion_control
	import touch_adc_pkg::*;
(
	// core clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rstn,
	// serial link from the host
	input  wire logic                   shiftClock,
	input  wire logic                   chipSelectN,
	input  wire logic                   commandIn,
	output logic                        serialOut,
	output logic                        serialOutOeN,
	output logic                        busyOut,
	output logic                        busyOeN,
	// converter result from the analog core
	input  wire logic [RESULT_BITS-1:0] adcCode,
	// analog control
	output logic                        adcPowered,
	output logic                        refPowered,
	output logic                        touchAlertArm,
	output logic                        biasSwitchOn,
	output logic [2:0]                  channelSel,
	output logic                        singleEnded,
	output logic                        conversionActive
);

	// ---------------- link domain ----------------
	logic                   linkClear;
	logic                   linkPor;
	link_phase_type         cmdPhase;
	logic [COUNT_W-1:0]     cmdCount;
	logic [CMD_BITS-2:0]    cmdShift;
	logic [CMD_BITS-1:0]    cmdByte;
	logic                   cmdToggle;
	logic                   cmdSeen;
	logic                   doneToggle;
	conv_phase_type         convPhase;
	logic [STEP_W-1:0]      convStep;
	logic [RESULT_BITS-1:0] resultWord;
	logic [RESULT_BITS-1:0] adcCodeLink;
	logic                   eightBit;
	logic                   bias;
	logic                   linkOff;

	wire logic              cmdPending;
	wire logic [STEP_W-1:0] finalStep;
	wire logic              lastStep;
	wire logic              startNow;
	wire logic              startAllowed;
	wire logic              byteDone;
	wire logic              acquiring;
	wire logic [CMD_BITS-1:0] fullByte;

	// select high clears the capture and conversion state without waiting for a clock
	assign linkClear = chipSelectN | ~rstn;
	assign linkPor   = ~rstn;

	assign cmdPending = cmdToggle != cmdSeen;
	assign finalStep  = eightBit ? SHORT_LAST : LONG_LAST;
	assign lastStep   = (convPhase == CONV_DATA) && (convStep == finalStep);
	// a pending command waits for the running conversion to end
	assign startNow   = cmdPending && ((convPhase == CONV_IDLE) || lastStep);
	assign startAllowed = (convPhase == CONV_IDLE)
		|| ((convPhase == CONV_DATA) && (convStep >= OVERLAP_STEP));
	assign byteDone   = (cmdPhase == LINK_COMMAND) && (cmdCount == CMD_LAST);
	assign fullByte   = {cmdShift, commandIn};
	assign acquiring  = ((cmdPhase == LINK_COMMAND) && (cmdCount >= BIAS_COUNT)) || cmdPending;

	sync_stage #(
		.WIDTH (RESULT_BITS)
	) codeSync (
		.clk     (shiftClock),
		.rstn    (rstn),
		.asyncIn (adcCode),
		.syncOut (adcCodeLink)
	);

	// command capture on the rising edge
	always_ff @(posedge shiftClock or posedge linkClear) begin
		if (linkClear) begin
			cmdPhase <= LINK_WAIT;
			cmdCount <= '0;
			cmdShift <= '0;
		end else begin
			case (cmdPhase)
				LINK_WAIT: begin
					// zeros before the start bit are ignored
					if (commandIn && startAllowed) begin
						cmdPhase <= LINK_COMMAND;
						cmdShift <= {{(CMD_BITS-2){1'b0}}, 1'b1};
						cmdCount <= CMD_FIRST;
					end
				end
				LINK_COMMAND: begin
					cmdShift <= fullByte[CMD_BITS-2:0];
					cmdCount <= cmdCount + CMD_FIRST;
					if (byteDone) begin
						cmdPhase <= LINK_WAIT;
					end
				end
				default: begin
					cmdPhase <= LINK_WAIT;
				end
			endcase
		end
	end

	// held byte and its event survive select so the core sees no false event
	always_ff @(posedge shiftClock or posedge linkPor) begin
		if (linkPor) begin
			cmdByte   <= '0;
			cmdToggle <= 1'b0;
		end else if (byteDone) begin
			cmdByte   <= fullByte;
			cmdToggle <= ~cmdToggle;
		end
	end

	// conversion sequencing on the falling edge
	always_ff @(negedge shiftClock or posedge linkClear) begin
		if (linkClear) begin
			convPhase  <= CONV_IDLE;
			convStep   <= STEP_ZERO;
			busyOut    <= 1'b0;
			serialOut  <= 1'b0;
			resultWord <= '0;
			eightBit   <= 1'b0;
			bias       <= 1'b0;
		end else if (startNow) begin
			convPhase  <= CONV_BUSY;
			convStep   <= STEP_ZERO;
			busyOut    <= 1'b1;
			serialOut  <= 1'b0;
			resultWord <= adcCodeLink;
			eightBit   <= cmdByte[RES_POS];
			// differential keeps the screen biased through conversion
			bias       <= ~cmdByte[SE_POS];
		end else begin
			case (convPhase)
				CONV_BUSY: begin
					busyOut    <= 1'b0;
					convPhase  <= CONV_DATA;
					convStep   <= STEP_ONE;
					serialOut  <= resultWord[RESULT_BITS-1];
					resultWord <= {resultWord[RESULT_BITS-2:0], 1'b0};
				end
				CONV_DATA: begin
					if (lastStep) begin
						convPhase <= CONV_IDLE;
						serialOut <= 1'b0;
						bias      <= acquiring;
					end else begin
						convStep   <= convStep + STEP_ONE;
						serialOut  <= resultWord[RESULT_BITS-1];
						resultWord <= {resultWord[RESULT_BITS-2:0], 1'b0};
						if (acquiring) begin
							bias <= 1'b1;
						end
					end
				end
				default: begin
					serialOut <= 1'b0;
					bias      <= acquiring;
				end
			endcase
		end
	end

	// pin drivers float whenever select is high
	always_ff @(negedge shiftClock or posedge linkClear) begin
		if (linkClear) begin
			linkOff <= 1'b1;
		end else begin
			linkOff <= 1'b0;
		end
	end

	assign serialOutOeN = linkOff;
	assign busyOeN      = linkOff;

	always_ff @(negedge shiftClock or posedge linkPor) begin
		if (linkPor) begin
			cmdSeen    <= 1'b0;
			doneToggle <= 1'b0;
		end else begin
			if (startNow) begin
				cmdSeen <= cmdToggle;
			end
			if (lastStep) begin
				doneToggle <= ~doneToggle;
			end
		end
	end

	// ---------------- core domain ----------------
	logic [CORE_SYNC_W-1:0] coreSync;
	logic                   cmdPrev;
	logic                   donePrev;
	logic                   selectPrev;
	power_mode_type         powerMode;
	power_mode_type         pendingMode;
	logic                   fullPower;

	wire logic [CORE_SYNC_W-1:0] syncIn;
	wire logic                   cmdEvent;
	wire logic                   doneEvent;
	wire logic                   selectRise;
	wire logic                   selectHigh;
	wire logic                   applyMode;
	wire logic                   next_adcPowered;
	wire logic                   next_refPowered;
	wire logic                   next_touchAlertArm;

	assign syncIn[SY_SELECT] = chipSelectN;
	assign syncIn[SY_CMD]    = cmdToggle;
	assign syncIn[SY_DONE]   = doneToggle;
	assign syncIn[SY_ACTIVE] = (convPhase != CONV_IDLE);
	assign syncIn[SY_BIAS]   = bias;

	sync_stage #(
		.WIDTH (CORE_SYNC_W)
	) coreSyncer (
		.clk     (core_clk),
		.rstn    (rstn),
		.asyncIn (syncIn),
		.syncOut (coreSync)
	);

	assign selectHigh = coreSync[SY_SELECT];
	assign cmdEvent   = coreSync[SY_CMD] != cmdPrev;
	assign doneEvent  = coreSync[SY_DONE] != donePrev;
	assign selectRise = selectHigh & ~selectPrev;
	assign applyMode  = (doneEvent | selectRise) & fullPower;

	// converter off while select is high; on in modes 1 and 3, on only from command to end of conversion in modes 0 and 2
	assign next_adcPowered = ~selectHigh & (fullPower | powerMode[ADC_PWR_POS]);
	// reference ignores select
	assign next_refPowered = powerMode[REF_PWR_POS]
		| (fullPower & pendingMode[REF_PWR_POS]);
	assign next_touchAlertArm = (powerMode == PWR_AUTO) & ~fullPower;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cmdPrev    <= 1'b0;
			donePrev   <= 1'b0;
			selectPrev <= 1'b0;
		end else begin
			cmdPrev    <= coreSync[SY_CMD];
			donePrev   <= coreSync[SY_DONE];
			selectPrev <= selectHigh;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			powerMode   <= POWER_ON_MODE;
			pendingMode <= POWER_ON_MODE;
			fullPower   <= 1'b0;
			channelSel  <= '0;
			singleEnded <= 1'b0;
		end else if (cmdEvent) begin
			// a new command restores full power until the next conversion end or select goes high
			pendingMode <= power_mode_type'(cmdByte[REF_PWR_POS:ADC_PWR_POS]);
			fullPower   <= 1'b1;
			channelSel  <= cmdByte[CHAN_HI_POS:CHAN_LO_POS];
			singleEnded <= cmdByte[SE_POS];
		end else if (applyMode) begin
			powerMode <= pendingMode;
			fullPower <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			adcPowered       <= 1'b0;
			refPowered       <= 1'b0;
			touchAlertArm    <= 1'b1;
			biasSwitchOn     <= 1'b0;
			conversionActive <= 1'b0;
		end else begin
			adcPowered       <= next_adcPowered;
			refPowered       <= next_refPowered;
			touchAlertArm    <= next_touchAlertArm;
			biasSwitchOn     <= coreSync[SY_BIAS] & ~selectHigh;
			conversionActive <= coreSync[SY_ACTIVE] & ~selectHigh;
		end
	end

endmodule

// ### touch_adc_pkg.sv
package touch_adc_pkg;

	localparam int CMD_BITS    = 8;
	localparam int RESULT_BITS = 12;
	localparam int SHORT_BITS  = 8;
	localparam int STEP_W      = 4;
	localparam int COUNT_W     = 3;

	// command byte fields
	localparam int START_POS   = 7;
	localparam int CHAN_HI_POS = 6;
	localparam int CHAN_LO_POS = 4;
	localparam int RES_POS     = 3;
	localparam int SE_POS      = 2;
	localparam int REF_PWR_POS = 1;
	localparam int ADC_PWR_POS = 0;

	localparam logic [COUNT_W-1:0] CMD_LAST     = 3'h7;
	localparam logic [COUNT_W-1:0] CMD_FIRST    = 3'h1;
	localparam logic [COUNT_W-1:0] BIAS_COUNT   = 3'h4;
	localparam logic [STEP_W-1:0]  OVERLAP_STEP = 4'h6;
	localparam logic [STEP_W-1:0]  LONG_LAST    = 4'hc;
	localparam logic [STEP_W-1:0]  SHORT_LAST   = 4'h8;
	localparam logic [STEP_W-1:0]  STEP_ZERO    = 4'h0;
	localparam logic [STEP_W-1:0]  STEP_ONE     = 4'h1;

	typedef enum logic [1:0] {
		PWR_AUTO    = 2'h0,
		PWR_ADC_ON  = 2'h1,
		PWR_REF_ON  = 2'h2,
		PWR_ALL_ON  = 2'h3
	} power_mode_type;

	localparam power_mode_type POWER_ON_MODE = PWR_AUTO;

	typedef enum logic {
		LINK_WAIT    = 1'b0,
		LINK_COMMAND = 1'b1
	} link_phase_type;

	typedef enum logic [1:0] {
		CONV_IDLE = 2'h0,
		CONV_BUSY = 2'h1,
		CONV_DATA = 2'h3
	} conv_phase_type;

	localparam int CORE_SYNC_W = 5;
	localparam int SY_SELECT   = 0;
	localparam int SY_CMD      = 1;
	localparam int SY_DONE     = 2;
	localparam int SY_ACTIVE   = 3;
	localparam int SY_BIAS     = 4;

endpackage

// ### sync_stage.sv
`timescale 1ns/1ps
module sync_stage #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// data
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] firstStage;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			firstStage <= '0;
			syncOut    <= '0;
		end else begin
			firstStage <= asyncIn;
			syncOut    <= firstStage;
		end
	end
endmodule

// ### touch_adc_monitor.sv
`timescale 1ns/1ps
module touch_adc_monitor
	import touch_adc_pkg::*;
(
	// clocks and reset
	input wire logic                   core_clk,
	input wire logic                   rstn,
	input wire logic                   shiftClock,
	// link
	input wire logic                   chipSelectN,
	input wire logic                   commandIn,
	input wire logic                   serialOut,
	input wire logic                   serialOutOeN,
	input wire logic                   busyOut,
	input wire logic                   busyOeN,
	// analog side
	input wire logic [RESULT_BITS-1:0] adcCode,
	input wire logic                   adcPowered,
	input wire logic                   refPowered,
	input wire logic                   touchAlertArm,
	input wire logic                   biasSwitchOn,
	input wire logic                   conversionActive
);
	property p_float;
		@(posedge core_clk) disable iff (!rstn) chipSelectN |-> serialOutOeN && busyOeN;
	endproperty
	a_float: assert property (p_float) else $error("output driven while deselected");
	property p_busy_one;
		@(negedge shiftClock) disable iff (!rstn || chipSelectN) $rose(busyOut) |=> !busyOut;
	endproperty
	a_busy_one: assert property (p_busy_one) else $error("busy not one period");
	property p_busy_start;
		@(negedge shiftClock) disable iff (!rstn || chipSelectN)
			$rose(busyOut) |-> $past(commandIn, 8);
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy without start bit");
	property p_busy_quiet;
		@(negedge shiftClock) disable iff (!rstn || chipSelectN) busyOut |-> !serialOut;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("data during busy");
	property p_msb;
		@(negedge shiftClock) disable iff (!rstn || chipSelectN)
			$fell(busyOut) |-> serialOut == adcCode[RESULT_BITS-1];
	endproperty
	a_msb: assert property (p_msb) else $error("first bit not msb");
	property p_reset_state;
		@(posedge core_clk) !rstn ##1 !rstn |-> !adcPowered && !refPowered && touchAlertArm;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("bad reset mode");
	property p_alert_mode;
		@(posedge core_clk) disable iff (!rstn) $rose(touchAlertArm) |-> ##1 !refPowered;
	endproperty
	a_alert_mode: assert property (p_alert_mode) else $error("alert with reference");
	property p_deselect_idle;
		@(posedge core_clk) disable iff (!rstn)
			chipSelectN [*8] |-> !conversionActive && !biasSwitchOn;
	endproperty
	a_deselect_idle: assert property (p_deselect_idle) else $error("active deselected");
	c_busy: cover property (@(negedge shiftClock) $rose(busyOut));
	c_end: cover property (@(posedge core_clk) $fell(conversionActive));
	c_alert: cover property (@(posedge core_clk) $rose(touchAlertArm));
endmodule
bind touch_adc_serial_conversion_control touch_adc_monitor mon (.core_clk, .rstn, .shiftClock,
	.chipSelectN, .commandIn, .serialOut, .serialOutOeN, .busyOut, .busyOeN, .adcCode,
	.adcPowered, .refPowered, .touchAlertArm, .biasSwitchOn, .conversionActive);

// ### host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
	// link to the device
	output logic            shiftClock,
	output logic            chipSelectN,
	output logic            commandIn,
	input  wire logic       serialOut,
	input  wire logic       serialOutOeN,
	input  wire logic       busyOut,
	input  wire logic       busyOeN
);
	logic        lastBit;
	logic [63:0] rxBits;
	logic [63:0] busyBits;
	// floating lines read back as a changing pattern
	wire         dataWire = serialOutOeN ? ~lastBit : serialOut;
	initial begin
		shiftClock = 1'b0;
		chipSelectN = 1'b1;
		commandIn = 1'b0;
		lastBit = 1'b0;
	end
	// clock runs only inside a frame; a short frame stops it mid-conversion
	task automatic frame(input logic [63:0] tx, input int n);
		chipSelectN = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			#1 commandIn = tx[i];
			#39 shiftClock = 1'b1;
			rxBits = {rxBits[62:0], dataWire};
			busyBits = {busyBits[62:0], busyOeN ? ~lastBit : busyOut};
			lastBit = dataWire;
			#40 shiftClock = 1'b0;
		end
		#40 chipSelectN = 1'b1;
	endtask
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import touch_adc_pkg::*;
	logic                   core_clk;
	logic                   rstn;
	logic                   shiftClock;
	logic                   chipSelectN;
	logic                   commandIn;
	logic                   serialOut;
	logic                   serialOutOeN;
	logic                   busyOut;
	logic                   busyOeN;
	logic [RESULT_BITS-1:0] adcCode;
	logic                   adcPowered;
	logic                   refPowered;
	logic                   touchAlertArm;
	logic                   biasSwitchOn;
	logic [2:0]             channelSel;
	logic                   singleEnded;
	logic                   conversionActive;
	integer                 seed = 32'h7eba;
	int                     failCount = 0;
	int                     comparisons = 0;
	initial core_clk = 1'b0;
	always #12.5 core_clk = ~core_clk;
	touch_adc_serial_conversion_control dut (.core_clk, .rstn, .shiftClock, .chipSelectN,
		.commandIn, .serialOut, .serialOutOeN, .busyOut, .busyOeN, .adcCode, .adcPowered,
		.refPowered, .touchAlertArm, .biasSwitchOn, .channelSel, .singleEnded,
		.conversionActive);
	host_link_model host (.shiftClock, .chipSelectN, .commandIn, .serialOut, .serialOutOeN,
		.busyOut, .busyOeN);
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			failCount++;
			$display("BAD %0t %s", $time, what);
		end
	endtask
	// bits read after the first clock of a 24-clock frame
	function automatic logic [22:0] reply24(input logic [7:0] c, input logic [11:0] code);
		return c[RES_POS] ? {8'h00, code[11:4], 7'h00} : {8'h00, code, 3'h0};
	endfunction
	task automatic stopTest;
		$display("comparisons %0d mismatches %0d", comparisons, failCount);
		if (failCount == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic conv(input logic [7:0] c);
		@(negedge core_clk) adcCode = 12'($random(seed));
		#7 fork
			host.frame(64'({c, 16'h0000}), 24);
		join_none
		// conversion over, select still low: commanded mode shows
		#1900 chk({refPowered, adcPowered, touchAlertArm},
			{c[1], c[0], c[1:0] == 2'h0}, "mode selected");
		wait fork;
		chk(host.rxBits[22:0], reply24(c, adcCode), "reply");
		chk(host.busyBits[22:0], 23'h008000, "busy");
		repeat (10) @(negedge core_clk);
		chk({channelSel, singleEnded}, {c[6:4], c[SE_POS]}, "fields");
		chk({refPowered, adcPowered, touchAlertArm, serialOutOeN, busyOeN},
			{c[1], 1'b0, c[1:0] == 2'h0, 2'h3}, "mode");
	endtask
	initial begin
		rstn = 1'b0;
		adcCode = 12'h000;
		repeat (3) @(negedge core_clk);
		rstn = 1'b1;
		chk({adcPowered, refPowered, touchAlertArm}, 3'h1, "reset mode");
		repeat (400) @(negedge core_clk);
		#7 host.frame(64'h0, 16);
		chk(host.rxBits[14:0], 15'h0000, "idle zeros");
		$display("test power_on done");
		for (int i = 0; i < 8; i++) conv(8'h80 | 8'(i * 9));
		repeat (12) conv(8'h80 | 8'($random(seed)));
		$display("test frames done");
		@(negedge core_clk);
		#7;
		fork
			host.frame(64'({8'h90, 6'h00}), 14);
		join_none
		#1000 chk({conversionActive, adcPowered, biasSwitchOn}, 3'h7, "running");
		#400 chk({conversionActive, adcPowered, biasSwitchOn}, 3'h0, "abort");
		$display("test abort done");
		repeat (400) @(negedge core_clk);
		@(negedge core_clk) adcCode = 12'($random(seed));
		#7 host.frame(64'({16'h0000, 8'hb7, 7'h00, 8'hda, 23'h0}), 62);
		chk(host.rxBits[45:0], {9'h0, adcCode, 3'h0, adcCode[11:4], 14'h0}, "overlap");
		chk(host.busyBits[45:0], (64'h1 << 37) | (64'h1 << 22), "overlap busy");
		repeat (10) @(negedge core_clk);
		chk({refPowered, adcPowered, touchAlertArm}, 3'h4, "overlap mode");
		$display("test overlap done");
		stopTest();
	end
	initial begin
		#200000;
		failCount++;
		$display("BAD %0t watchdog", $time);
		stopTest();
	end
endmodule
